// *** verilog/acs_pkg.sv ***
package acs_pkg;

    // Register offsets.
    localparam logic [7:0] OSR_ADDR    = 8'h14;
    localparam logic [7:0] BUDGET_ADDR = 8'h15;
    localparam logic [7:0] DECIM_ADDR  = 8'h16;
    localparam logic [7:0] CKSRC_ADDR  = 8'h19;
    localparam logic [7:0] CKDIV_ADDR  = 8'h1a;
    localparam logic [7:0] SIF_ADDR    = 8'h1b;
    localparam logic [7:0] SLOT_ADDR   = 8'h1c;
    localparam logic [7:0] OFFEN_ADDR  = 8'h26;

    // Reset values.
    localparam logic [7:0] OSR_RST    = 8'h80;
    localparam logic [7:0] BUDGET_RST = 8'h80;
    localparam logic [7:0] DECIM_RST  = 8'h04;
    localparam logic [7:0] CKSRC_RST  = 8'h00;
    localparam logic [7:0] CKDIV_RST  = 8'h01;
    localparam logic [7:0] SIF_RST    = 8'h00;
    localparam logic [7:0] SLOT_RST   = 8'h00;
    localparam logic [7:0] OFFEN_RST  = 8'h00;

    // Writable bits per register.
    localparam logic [7:0] DECIM_WMASK = 8'h0f;
    localparam logic [7:0] CKSRC_WMASK = 8'h07;
    localparam logic [7:0] SIF_WMASK   = 8'hfd;
    localparam logic [7:0] OFFEN_WMASK = 8'h01;

    // Field positions.
    localparam int SIF_FMT_LSB  = 6;
    localparam int SIF_WL_LSB   = 4;
    localparam int SIF_BCLK_BIT = 3;
    localparam int SIF_WCLK_BIT = 2;
    localparam int SIF_TRI_BIT  = 0;
    localparam int CKDIV_PWR    = 7;
    localparam int OFFEN_BIT    = 0;

    // Half frame in bit clocks, bit clock half period in cycles.
    localparam int HALF_BITS        = 32;
    localparam int BCLK_HALF_CYCLES = 4;

    typedef enum logic [1:0] {
        ACS_FMT_I2S   = 2'b00,
        ACS_FMT_DSP   = 2'b01,
        ACS_FMT_RIGHT = 2'b10,
        ACS_FMT_LEFT  = 2'b11
    } acs_fmt_t;

    typedef enum logic [2:0] {
        ACS_SRC_MCLK = 3'b000,
        ACS_SRC_BCLK = 3'b001,
        ACS_SRC_PLL  = 3'b011,
        ACS_SRC_CONV = 3'b110,
        ACS_SRC_MOD  = 3'b111
    } acs_src_t;

    // Stereo sample pair, right aligned in each word.
    typedef struct packed {
        logic [31:0] left;
        logic [31:0] right;
    } acs_sample_t;

endpackage

// *** verilog/acs_config.sv ***
`timescale 1ns/1ns
// How it works
// [RQ1] Oversample ratio: zero means 256, reset 128.
// [RQ2] Host keeps ratio a multiple of decimation.
// [RQ3] Instruction budget is twice code, max 510.
// [RQ4] Host keeps budget a multiple of decimation.
// [RQ5] Decimation field: zero means 16, reset 4.
// [RQ6] Host writes reserved read-only bits as reset.
// [RQ7] Host never writes the two reserved slots.
// [RQ8] Clock output source select, three reserved codes.
// [RQ9] Divider power bit, reset powered down.
// [RQ10] Divider M: zero means 128, reset 1.
// [RQ11] Serial format: I2S, DSP, right, left justified.
// [RQ12] Word length 16, 20, 24 or 32.
// [RQ13] Bit clock direction follows control bit 3.
// [RQ14] Frame clock direction follows control bit 2.
// [RQ15] Data output floats outside slots when enabled.
// [RQ16] First slot delayed 0 to 255 bit clocks.
// [RQ17] Offset applied only when enable bit set.
// [RQ18] Clock output toggles source over M, else static.
module acs_config (
    input  wire logic                sys_clk_i,
    input  wire logic                rst_i,
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [7:0]          reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [7:0]          reg_rdata_o,
    input  wire logic                mclk_i,
    input  wire logic                pll_clk_i,
    input  wire logic                conv_clk_i,
    input  wire logic                modulator_clock_i,
    input  wire logic                bclk_i,
    output logic                     bclk_o,
    output logic                     bclk_oe_o,
    input  wire logic                wclk_i,
    output logic                     wclk_o,
    output logic                     wclk_oe_o,
    output logic                     dout_o,
    output logic                     dout_oe_o,
    input  wire acs_pkg::acs_sample_t sample_i,
    output logic                     sample_ack_o,
    output logic                     clock_output_o,
    output logic      [8:0]          oversample_ratio_o,
    output logic      [8:0]          instr_budget_o,
    output logic      [4:0]          decimation_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [7:0] osr, budget, decim, cksrc, ckdiv, sif, slot, offen;
    logic [7:0] next_osr, next_budget, next_decim, next_cksrc;
    logic [7:0] next_ckdiv, next_sif, next_slot, next_offen, next_rdata;
    logic [8:0] next_osr_val, next_budget_val;
    logic [4:0] next_decim_val;

    // Writes land on the addressed register; holes read as zero.
    always_comb begin
        next_osr    = osr;
        next_budget = budget;
        next_decim  = decim;
        next_cksrc  = cksrc;
        next_ckdiv  = ckdiv;
        next_sif    = sif;
        next_slot   = slot;
        next_offen  = offen;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                acs_pkg::OSR_ADDR:    next_osr    = reg_wdata_i;
                acs_pkg::BUDGET_ADDR: next_budget = reg_wdata_i;
                acs_pkg::DECIM_ADDR:  next_decim  = reg_wdata_i & acs_pkg::DECIM_WMASK;
                acs_pkg::CKSRC_ADDR:  next_cksrc  = reg_wdata_i & acs_pkg::CKSRC_WMASK;
                acs_pkg::CKDIV_ADDR:  next_ckdiv  = reg_wdata_i;
                acs_pkg::SIF_ADDR:    next_sif    = reg_wdata_i & acs_pkg::SIF_WMASK;
                acs_pkg::SLOT_ADDR:   next_slot   = reg_wdata_i;
                acs_pkg::OFFEN_ADDR:  next_offen  = reg_wdata_i & acs_pkg::OFFEN_WMASK;
                default: ;
            endcase
        end
        next_rdata = reg_rdata_o;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                acs_pkg::OSR_ADDR:    next_rdata = osr;
                acs_pkg::BUDGET_ADDR: next_rdata = budget;
                acs_pkg::DECIM_ADDR:  next_rdata = decim;
                acs_pkg::CKSRC_ADDR:  next_rdata = cksrc;
                acs_pkg::CKDIV_ADDR:  next_rdata = ckdiv;
                acs_pkg::SIF_ADDR:    next_rdata = sif;
                acs_pkg::SLOT_ADDR:   next_rdata = slot;
                acs_pkg::OFFEN_ADDR:  next_rdata = offen;
                default:              next_rdata = 8'h00;
            endcase
        end
        next_osr_val    = (osr == 8'h00) ? 9'h100 : {1'b0, osr}; // [RQ1]
        next_budget_val = {budget, 1'b0}; // [RQ3]
        next_decim_val  = (decim[3:0] == 4'h0) ? 5'h10 : {1'b0, decim[3:0]}; // [RQ5]
    end

    // Register reset values come from the package; decoded outputs reset to literals.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            osr                <= acs_pkg::OSR_RST; // [RQ1]
            budget             <= acs_pkg::BUDGET_RST;
            decim              <= acs_pkg::DECIM_RST; // [RQ5]
            cksrc              <= acs_pkg::CKSRC_RST;
            ckdiv              <= acs_pkg::CKDIV_RST; // [RQ9] [RQ10]
            sif                <= acs_pkg::SIF_RST;
            slot               <= acs_pkg::SLOT_RST;
            offen              <= acs_pkg::OFFEN_RST;
            reg_rdata_o        <= 8'h00;
            oversample_ratio_o <= 9'h080;
            instr_budget_o     <= 9'h100;
            decimation_o       <= 5'h04;
        end else begin
            osr                <= next_osr;
            budget             <= next_budget;
            decim              <= next_decim;
            cksrc              <= next_cksrc;
            ckdiv              <= next_ckdiv;
            sif                <= next_sif;
            slot               <= next_slot;
            offen              <= next_offen;
            reg_rdata_o        <= next_rdata;
            oversample_ratio_o <= next_osr_val;
            instr_budget_o     <= next_budget_val;
            decimation_o       <= next_decim_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a level counts once stages two and three agree.

    logic [5:0] pins, sync1, sync2, sync3, filt;
    logic [5:0] next_sync1, next_filt;

    assign pins = {modulator_clock_i, conv_clk_i, pll_clk_i, wclk_i, bclk_i, mclk_i};

    // The filter looks at stages two and three only.
    always_comb begin
        next_sync1 = pins;
        next_filt  = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            sync3 <= 6'h00;
            filt  <= 6'h00;
        end else begin
            sync1 <= next_sync1;
            sync2 <= sync1;
            sync3 <= sync2;
            filt  <= next_filt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock output divider.

    logic       src_lvl, src_prev, src_ok, next_cko;
    logic [6:0] ck_cnt, next_ck_cnt;
    logic [7:0] m_val;

    // Source pins sampled here, so the output is only faithful well below half sys_clk.
    always_comb begin
        src_ok = 1'b1;
        unique case (acs_pkg::acs_src_t'(cksrc[2:0])) // [RQ8]
            acs_pkg::ACS_SRC_MCLK: src_lvl = filt[0];
            acs_pkg::ACS_SRC_BCLK: src_lvl = filt[1];
            acs_pkg::ACS_SRC_PLL:  src_lvl = filt[3];
            acs_pkg::ACS_SRC_CONV: src_lvl = filt[4];
            acs_pkg::ACS_SRC_MOD:  src_lvl = filt[5];
            default: begin
                src_lvl = 1'b0;
                src_ok  = 1'b0;
            end
        endcase
        m_val       = (ckdiv[6:0] == 7'h00) ? 8'h80 : {1'b0, ckdiv[6:0]}; // [RQ10]
        next_ck_cnt = ck_cnt;
        if (src_lvl && !src_prev) begin
            next_ck_cnt = ({1'b0, ck_cnt} + 8'h01 >= m_val) ? 7'h00 : ck_cnt + 7'h01;
        end
        if (m_val == 8'h01) begin
            next_cko = src_lvl;
        end else begin
            next_cko = ({1'b0, next_ck_cnt} < (m_val >> 1)); // [RQ18]
        end
        if (!ckdiv[acs_pkg::CKDIV_PWR] || !src_ok) begin // [RQ9]
            next_ck_cnt = 7'h00;
            next_cko    = 1'b0; // [RQ18]
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            src_prev       <= 1'b0;
            ck_cnt         <= 7'h00;
            clock_output_o <= 1'b0;
        end else begin
            src_prev       <= src_lvl;
            ck_cnt         <= next_ck_cnt;
            clock_output_o <= next_cko;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial audio interface.

    localparam logic [9:0] HALF  = 10'(acs_pkg::HALF_BITS);
    localparam logic [9:0] FRAME = 10'(2 * acs_pkg::HALF_BITS);

    acs_pkg::acs_fmt_t fmt;
    acs_pkg::acs_sample_t shadow, next_shadow, cur;
    logic        bclk_dir, wclk_dir, tri_en;
    logic [2:0]  hcnt, next_hcnt;
    logic        bgen, next_bgen, bext_prev, wext_prev, next_wext_prev;
    logic        rise_t, fall_t, start_pend, next_start_pend;
    logic [9:0]  pos, next_pos, wl, off, start_l, start_r, rel;
    logic        in_l, in_r, next_wclk, next_dout, next_dout_oe, next_ack;
    logic [31:0] word;
    logic [4:0]  idx;

    assign fmt      = acs_pkg::acs_fmt_t'(sif[acs_pkg::SIF_FMT_LSB +: 2]); // [RQ11]
    assign bclk_dir = sif[acs_pkg::SIF_BCLK_BIT];
    assign wclk_dir = sif[acs_pkg::SIF_WCLK_BIT];
    assign tri_en   = sif[acs_pkg::SIF_TRI_BIT];

    // Bit clock ticks: internal divider or the far party's pin.
    always_comb begin
        next_hcnt = (hcnt == 3'(acs_pkg::BCLK_HALF_CYCLES - 1)) ? 3'h0 : hcnt + 3'h1;
        next_bgen = (hcnt == 3'(acs_pkg::BCLK_HALF_CYCLES - 1)) ? ~bgen : bgen;
        if (bclk_dir) begin // [RQ13]
            rise_t = (next_bgen && !bgen);
            fall_t = (!next_bgen && bgen);
        end else begin
            rise_t = (filt[1] && !bext_prev);
            fall_t = (!filt[1] && bext_prev);
        end
    end

    // Frame position, slot timing and the data shift.
    always_comb begin
        unique case (sif[acs_pkg::SIF_WL_LSB +: 2]) // [RQ12]
            2'b00: wl = 10'd16;
            2'b01: wl = 10'd20;
            2'b10: wl = 10'd24;
            2'b11: wl = 10'd32;
        endcase
        off     = offen[acs_pkg::OFFEN_BIT] ? {2'b00, slot} : 10'h000; // [RQ16] [RQ17]
        start_l = off + ((fmt == acs_pkg::ACS_FMT_I2S) ? 10'h001 : 10'h000);
        if (fmt == acs_pkg::ACS_FMT_RIGHT) begin
            start_l = off + HALF - wl;
        end
        start_r = (fmt == acs_pkg::ACS_FMT_DSP) ? start_l + wl : start_l + HALF;
        // A slave frame starts on the wclk edge that opens the left slot.
        next_wext_prev  = rise_t ? filt[2] : wext_prev;
        next_start_pend = start_pend;
        if (rise_t) begin
            if (fmt == acs_pkg::ACS_FMT_I2S) begin
                next_start_pend = start_pend | (wext_prev && !filt[2]);
            end else begin
                next_start_pend = start_pend | (!wext_prev && filt[2]);
            end
        end
        next_pos = pos;
        if (fall_t) begin
            if (wclk_dir) begin // [RQ14]
                next_pos = (pos == FRAME - 10'h001) ? 10'h000 : pos + 10'h001;
            end else if (start_pend) begin
                next_pos = 10'h000;
            end else if (pos != 10'h3ff) begin
                next_pos = pos + 10'h001;
            end
            next_start_pend = 1'b0;
        end
        unique case (fmt)
            acs_pkg::ACS_FMT_I2S: next_wclk = (next_pos >= HALF);
            acs_pkg::ACS_FMT_DSP: next_wclk = (next_pos == 10'h000);
            default:              next_wclk = (next_pos < HALF);
        endcase
        if (!fall_t) begin
            next_wclk = wclk_o;
        end
        cur         = (next_pos == 10'h000) ? sample_i : shadow;
        next_ack    = fall_t && (next_pos == 10'h000);
        next_shadow = next_ack ? sample_i : shadow;
        in_l        = (next_pos >= start_l) && (next_pos < start_l + wl);
        in_r        = (next_pos >= start_r) && (next_pos < start_r + wl);
        rel         = in_l ? next_pos - start_l : next_pos - start_r;
        idx         = 5'(wl - 10'h001 - rel);
        word        = in_l ? cur.left : cur.right;
        next_dout    = dout_o;
        next_dout_oe = dout_oe_o || !tri_en; // [RQ15]
        if (fall_t) begin
            next_dout    = (in_l || in_r) ? word[idx] : 1'b0;
            next_dout_oe = in_l || in_r || !tri_en; // [RQ15]
        end
    end

    // Frame clock and data bit change only on bit clock falling ticks so the far party samples on rising.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hcnt         <= 3'h0;
            bgen         <= 1'b0;
            bext_prev    <= 1'b0;
            wext_prev    <= 1'b0;
            start_pend   <= 1'b0;
            pos          <= 10'h000;
            shadow       <= '0;
            bclk_o       <= 1'b0;
            bclk_oe_o    <= 1'b0;
            wclk_o       <= 1'b0;
            wclk_oe_o    <= 1'b0;
            dout_o       <= 1'b0;
            dout_oe_o    <= 1'b1;
            sample_ack_o <= 1'b0;
        end else begin
            hcnt         <= next_hcnt;
            bgen         <= next_bgen;
            bext_prev    <= filt[1];
            wext_prev    <= next_wext_prev;
            start_pend   <= next_start_pend;
            pos          <= next_pos;
            shadow       <= next_shadow;
            bclk_o       <= next_bgen;
            bclk_oe_o    <= bclk_dir; // [RQ13]
            wclk_o       <= next_wclk;
            wclk_oe_o    <= wclk_dir; // [RQ14]
            dout_o       <= next_dout;
            dout_oe_o    <= next_dout_oe;
            sample_ack_o <= next_ack;
        end
    end

endmodule // acs_config

// *** verif/acs_config_props.sv ***
`timescale 1ns/1ns
module acs_config_props (
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       bclk_o,
    input wire logic       bclk_oe_o,
    input wire logic       wclk_oe_o,
    input wire logic       dout_oe_o,
    input wire logic       clock_output_o,
    input wire logic [8:0] oversample_ratio_o,
    input wire logic [8:0] instr_budget_o,
    input wire logic [4:0] decimation_o
);
    // One clock domain for all properties.
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    // Decoded values settle two edges after a write.
    a_osr_decode: assert property (
        reg_wr_i && reg_addr_i == acs_pkg::OSR_ADDR |-> ##2 oversample_ratio_o ==
        ($past(reg_wdata_i, 2) == 8'h00 ? 9'h100 : {1'b0, $past(reg_wdata_i, 2)}))
        else $error("ratio decode wrong");
    a_budget_double: assert property (
        reg_wr_i && reg_addr_i == acs_pkg::BUDGET_ADDR |-> ##2
        instr_budget_o == {$past(reg_wdata_i, 2), 1'b0})
        else $error("budget decode wrong");
    a_decim_decode: assert property (
        reg_wr_i && reg_addr_i == acs_pkg::DECIM_ADDR |-> ##2 decimation_o ==
        (($past(reg_wdata_i, 2) & 8'h0f) == 8'h00 ? 5'h10 : 5'($past(reg_wdata_i, 2) & 8'h0f)))
        else $error("decimation decode wrong");
    // Holes and reserved source bits read as zero.
    a_src_reserved: assert property (
        reg_rd_i && reg_addr_i == acs_pkg::CKSRC_ADDR |=> reg_rdata_o[7:3] == 5'h00)
        else $error("source reserved bits set");
    a_hole_zero: assert property (
        reg_rd_i && reg_addr_i == 8'h17 |=> reg_rdata_o == 8'h00)
        else $error("hole reads nonzero");
    // Pin directions follow the control bits.
    a_bclk_dir: assert property (
        reg_wr_i && reg_addr_i == acs_pkg::SIF_ADDR |-> ##2
        bclk_oe_o == $past(reg_wdata_i[3], 2))
        else $error("bit clock direction wrong");
    a_wclk_dir: assert property (
        reg_wr_i && reg_addr_i == acs_pkg::SIF_ADDR |-> ##2
        wclk_oe_o == $past(reg_wdata_i[2], 2))
        else $error("frame clock direction wrong");
    a_tri_off: assert property (
        reg_wr_i && reg_addr_i == acs_pkg::SIF_ADDR && !reg_wdata_i[0] |-> ##3 dout_oe_o[*4])
        else $error("data output released");
    // A powered-down divider leaves the clock output low and still.
    a_clock_output_static: assert property (
        reg_wr_i && reg_addr_i == acs_pkg::CKDIV_ADDR && !reg_wdata_i[7] ##1
        !(reg_wr_i && reg_addr_i == acs_pkg::CKDIV_ADDR)[*6] |-> !clock_output_o)
        else $error("clock output moves while off");
    // A generated bit clock rests four cycles low after four cycles high.
    a_bclk_half: assert property (
        $rose(bclk_o) && bclk_oe_o && $past(bclk_oe_o, 16) |->
        !$past(bclk_o, 4) && $past(bclk_o, 5))
        else $error("bit clock half period wrong");
endmodule // acs_config_props

bind acs_config acs_config_props u_props (
    .sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bclk_o,
    .bclk_oe_o, .wclk_oe_o, .dout_oe_o, .clock_output_o, .oversample_ratio_o, .instr_budget_o,
    .decimation_o
);

// *** verif/acs_host_model.sv ***
`timescale 1ns/1ns
module acs_host_model (
    input  wire logic        run_i,
    input  wire logic        dout_i,
    output logic             bclk_o,
    output logic             wclk_o,
    output logic      [63:0] frame_o,
    output logic             done_o
);
    localparam int HALF_NS = 83;
    ////////////////////////////////////////
    // The bit clock rests low between frames.
    initial begin
        bclk_o = 1'b0;
        wclk_o = 1'b0;
        frame_o = 64'h0;
        done_o = 1'b0;
    end
    // One frame of 64 bits; the frame clock moves with a rising bit clock.
    always begin
        @(posedge run_i);
        done_o = 1'b0;
        for (int k = 0; k <= 64; k++) begin
            #(HALF_NS);
            bclk_o = 1'b1;
            if (k == 0) wclk_o = 1'b1;
            else frame_o = {frame_o[62:0], dout_i};
            if (k == 32) wclk_o = 1'b0;
            #(HALF_NS);
            bclk_o = 1'b0;
        end
        done_o = 1'b1;
    end
endmodule // acs_host_model

// *** verif/acs_config_bench.sv ***
`timescale 1ns/1ns
module acs_config_bench;
    logic                 sys_clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic [7:0]           reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
    logic                 reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [3:0]           src = 4'h0;
    acs_pkg::acs_sample_t sample_i = '0;
    logic                 host_run = 1'b0, prev_out = 1'b0;
    logic [7:0]           reg_rdata_o;
    logic                 bclk_o, bclk_oe_o, wclk_o, wclk_oe_o, dout_o, dout_oe_o;
    logic                 sample_ack_o, clock_output_o, host_bclk, host_wclk, host_done;
    logic [63:0]          host_frame;
    logic [8:0]           osr_o, budget_o;
    logic [4:0]           decim_o;
    int                   errors = 0, checks_done = 0, rises = 0;
    logic [7:0] addrs [8] = '{8'h14, 8'h15, 8'h16, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h26};
    logic [7:0] rsts  [8] = '{8'h80, 8'h80, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [7:0] masks [8] = '{8'hff, 8'hff, 8'h0f, 8'h07, 8'hff, 8'hfd, 8'hff, 8'h01};
    ////////////////////////////////////////
    // Source clocks of 6, 14, 10 and 12 cycles change between system edges.
    always #4 sys_clk_i = ~sys_clk_i;
    always #24 src[0] = ~src[0];
    always #56 src[1] = ~src[1];
    always #40 src[2] = ~src[2];
    always #48 src[3] = ~src[3];
    acs_config dut (
        .sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .mclk_i(src[0]), .pll_clk_i(src[1]), .conv_clk_i(src[2]), .modulator_clock_i(src[3]),
        .bclk_i(bclk_oe_o ? bclk_o : host_bclk), .bclk_o, .bclk_oe_o,
        .wclk_i(wclk_oe_o ? wclk_o : host_wclk), .wclk_o, .wclk_oe_o, .dout_o, .dout_oe_o,
        .sample_i, .sample_ack_o, .clock_output_o, .oversample_ratio_o(osr_o),
        .instr_budget_o(budget_o), .decimation_o(decim_o)
    );
    acs_host_model host (
        .run_i(host_run), .dout_i(dout_oe_o ? dout_o : ~dout_o), .bclk_o(host_bclk),
        .wclk_o(host_wclk), .frame_o(host_frame), .done_o(host_done)
    );
    // Counts clock output rising edges.
    always @(posedge sys_clk_i) begin
        prev_out <= clock_output_o;
        if (clock_output_o && !prev_out) rises <= rises + 1;
    end
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        step(1);
        reg_wr_i = 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        step(1);
        reg_rd_i = 1'b0;
        step(1);
        d = reg_rdata_o;
    endtask
    function automatic logic [8:0] zero_is(input logic [7:0] code, input logic [8:0] top);
        return (code == 8'h00) ? top : {1'b0, code};
    endfunction
    function automatic int slot_start(input logic [1:0] fmt, input int wlen, input int off);
        case (fmt)
            2'b00: return off + 1;
            2'b10: return off + 32 - wlen;
            default: return off;
        endcase
    endfunction
    // Decimation first keeps ratio and budget whole multiples.
    task automatic dec_case(input logic [7:0] d, input logic [7:0] o, input logic [7:0] b);
        logic [7:0] v;
        wr(acs_pkg::DECIM_ADDR, d);
        wr(acs_pkg::OSR_ADDR, o);
        wr(acs_pkg::BUDGET_ADDR, b);
        step(3);
        chk("decim", zero_is(d, 9'h010), {4'h0, decim_o});
        chk("osr", zero_is(o, 9'h100), osr_o);
        chk("budget", {b, 1'b0}, budget_o);
        rd(acs_pkg::OSR_ADDR, v);
        chk("osr_reg", o, v);
    endtask
    // Four output periods per window, one edge of slack.
    task automatic clk_case(input logic [2:0] code, input int per, input logic pwr, input int mv);
        int w;
        w = (per == 0) ? 400 : per * mv * 4;
        wr(acs_pkg::CKSRC_ADDR, {5'h00, code});
        wr(acs_pkg::CKDIV_ADDR, {pwr, 7'(mv)});
        step(40);
        rises = 0;
        step(w);
        chk("clock_output_rises", (per == 0) ? 0 : 4, (rises > 2 && rises < 6) ? 4 : rises);
    endtask
    // Master frame: sample mid-bit, four cycles after each falling tick.
    task automatic ser_case(input logic [1:0] fmt, input logic [1:0] wl);
        int wlen, st, rs, got;
        logic [31:0] lw, rw;
        logic [7:0] off;
        logic tri_on, oen, ed, eo;
        wlen = (wl == 2'b11) ? 32 : 16 + 4 * wl;
        lw = $urandom;
        off = 8'($urandom % 8);
        oen = 1'($urandom);
        tri_on = 1'($urandom);
        sample_i.left = lw;
        rw = $urandom;
        sample_i.right = rw;
        wr(acs_pkg::SIF_ADDR, {fmt, wl, 3'b110, tri_on});
        wr(acs_pkg::SLOT_ADDR, off);
        wr(acs_pkg::OFFEN_ADDR, {7'h00, oen});
        st = slot_start(fmt, wlen, oen ? off : 0);
        rs = st + ((fmt == 2'b01) ? wlen : 32);
        got = 0;
        for (int n = 0; n < 2000 && got < 2; n++) begin
            step(1);
            if (sample_ack_o === 1'b1) got++;
        end
        chk("ack", 2, got);
        chk("dirs", 2'b11, {bclk_oe_o, wclk_oe_o});
        step(4);
        for (int p = 0; p < 32; p++) begin
            eo = (p >= st && p < st + wlen) || (p >= rs && p < rs + wlen);
            ed = !eo ? 1'b0 : (p < rs) ? lw[wlen - 1 - p + st] : rw[wlen - 1 - p + rs];
            chk("wclk", (fmt == 2'b00) ? 0 : (fmt == 2'b01) ? (p == 0) : 1, wclk_o);
            chk("dout_oe", eo || !tri_on, dout_oe_o);
            if (eo || !tri_on) chk("dout", ed, dout_o);
            step(8);
        end
    endtask
    task automatic wrap_up;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    // Reset, registers, decoding, clock output, master and slave frames.
    initial begin
        logic [7:0] v;
        int d;
        void'($urandom(32'h0696c4bb));
        step(8);
        rst_i = 1'b0;
        chk("osr_rst", 9'h080, osr_o);
        chk("budget_rst", 9'h100, budget_o);
        chk("decim_rst", 9'h004, {4'h0, decim_o});
        for (int i = 0; i < 8; i++) begin
            rd(addrs[i], v);
            chk("reg_rst", rsts[i], v);
        end
        rd(8'h17, v);
        chk("hole_rd", 8'h00, v);
        for (int i = 3; i < 8; i++) begin
            d = $urandom & masks[i];
            wr(addrs[i], d[7:0]);
            rd(addrs[i], v);
            chk("reg_rw", d, v);
        end
        dec_case(8'h00, 8'h00, 8'h80);
        dec_case(8'h01, 8'hc0, 8'hff);
        for (int n = 0; n < 6; n++) begin
            d = 1 + $urandom % 15;
            dec_case(d[7:0], 8'(d * (1 + $urandom % (255 / d))), 8'(d * (1 + $urandom % (255 / d))));
        end
        wr(acs_pkg::SIF_ADDR, 8'h0c);
        clk_case(3'b000, 6, 1'b1, 1 + $urandom % 4);
        clk_case(3'b001, 8, 1'b1, 1 + $urandom % 4);
        clk_case(3'b011, 14, 1'b1, 1 + $urandom % 4);
        clk_case(3'b110, 10, 1'b1, 1 + $urandom % 4);
        clk_case(3'b111, 12, 1'b1, 128);
        for (int c = 2; c < 6; c++) clk_case((c == 3) ? 3'b000 : 3'(c), 0, c != 3, 2);
        for (int f = 0; f < 16; f++) ser_case(2'(f >> 2), 2'(f));
        sample_i.left = $urandom;
        wr(acs_pkg::SIF_ADDR, 8'hc0);
        wr(acs_pkg::OFFEN_ADDR, 8'h00);
        step(20);
        chk("slave_dirs", 2'b00, {bclk_oe_o, wclk_oe_o});
        host_run = 1'b1;
        for (int n = 0; n < 5000 && host_done !== 1'b1; n++) step(1);
        host_run = 1'b0;
        chk("slave_word", sample_i.left[15:0], host_frame[63:48]);
        wrap_up();
    end
    // Hang guard: about three times the expected run.
    initial begin
        repeat (90000) @(posedge sys_clk_i);
        errors++;
        wrap_up();
    end
endmodule // acs_config_bench
